// file: spi_diag_pkg.sv
package spi_diag_pkg;
    // ****************************************************************
    // frame layout
    // ****************************************************************
    localparam int FRAME_BITS = 8;
    localparam int CNT_BITS = 3;
    localparam logic [1:0] CMD_WRITE_OUT = 2'h2;
    localparam logic [1:0] CMD_DIAG = 2'h3;
    localparam logic [2:0] DCR_SEL_CODE = 3'h7;
    localparam int MUX_LSB = 0;
    localparam int MUX_MSB = 2;
    localparam int BYPASS_BIT = 3;
    localparam int ERR_MSB = 5;
    localparam int NUM_CHANNELS = 6;
    // ****************************************************************
    // reset values and mux codes
    // ****************************************************************
    localparam logic [2:0] MUX_RESET = 3'h7;
    localparam logic [2:0] MUX_OFF = 3'h6;
    localparam logic [2:0] MUX_STANDBY = 3'h7;
    localparam logic [5:0] ON_RESET = 6'h00;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int SENSE_SETTLE_US = 25;
    localparam int SENSE_SETTLE_CYC = (SENSE_SETTLE_US * 1000) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = 8;
    localparam int CS_GUARD_CYC = 40;
    // ****************************************************************
    // host register offsets
    // ****************************************************************
    localparam logic [3:0] ADDR_TXDATA = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_RXDATA = 4'h3;
    localparam logic [3:0] ADDR_CHAIN = 4'h4;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LEAD = 3'b001,
        H_LOW = 3'b010,
        H_HIGH = 3'b011,
        H_LAG = 3'b100
    } host_state_type;
endpackage

// file: spi_diag_if.sv
`timescale 1ns/10ps
interface spi_diag_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport device (input cs_n, input sclk, input mosi,
        output miso, output miso_oe);
    modport host (output cs_n, output sclk, output mosi,
        input miso, input miso_oe);
endinterface

// file: spi_diag_device.sv
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
// Notes on behaviour
// - sample on sclk fall, drive on rise
// - accept frame only at multiple of eight
// - deselected: ignore link, output released
// - select fall loads response word
// - first bit is error flag or input
// - bad length sets error, drops command
// - good length decodes and writes register
// - master keeps sclk low at select edges
// - input msb first, control bits first
// - response shifted out msb first
// - one shift register passes bits through
// - master clocks eight bits per device
// - three-bit sense select at bits 2:0
// - codes 0-5 route channel when on
// - channel off keeps sense released
// - code 111 is stand-by, released
// - bypass monitor read at bit 3
// - per-channel fault flags in diagnosis
// - sense valid 25 us after route change with channel on
module spi_diag_device (
    input wire logic CLK,
    input wire logic RESETN,
    spi_diag_if.device LINK,
    input wire logic [5:0] CHANNEL_ON,
    input wire logic [5:0] CHANNEL_FAULT,
    input wire logic BYPASS_ABOVE,
    output logic [2:0] SENSE_ROUTE_SEL,
    output logic SENSE_ENABLE,
    output logic [2:0] SENSE_CHANNEL,
    output logic SENSE_VALID,
    output logic FRAME_ERROR
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] s1_q, s2_q;
    logic cs_prev_q, sclk_prev_q;
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s1_q <= 3'h1;
            s2_q <= 3'h1;
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            s1_q <= {LINK.mosi, LINK.sclk, LINK.cs_n};
            s2_q <= s1_q;
            cs_prev_q <= s2_q[0];
            sclk_prev_q <= s2_q[1];
        end
    end
    wire cs_n = s2_q[0];
    wire sclk = s2_q[1];
    wire mosi = s2_q[2];
    wire cs_fall = cs_prev_q & ~cs_n;
    wire cs_rise = ~cs_prev_q & cs_n;
    // deselected edges are ignored
    wire sclk_rise = ~cs_n & ~sclk_prev_q & sclk;
    wire sclk_fall = ~cs_n & sclk_prev_q & ~sclk;
    // ****************************************************************
    // shift engine
    // ****************************************************************
    logic [7:0] shift_q, shift_d;
    logic [2:0] cnt_q, cnt_d;
    logic any_q, any_d;
    logic first_q, first_d;
    logic out_q, out_d;
    logic err_q, err_d;
    logic [2:0] mux_q, mux_d;
    logic [2:0] mux_prev_q;
    logic [9:0] settle_q;
    // response word loaded at select fall
    wire [7:0] diag_word = {2'h0, CHANNEL_FAULT};
    wire [7:0] dcr_word = {4'h0, BYPASS_ABOVE, mux_q};
    wire [1:0] cmd = shift_q[7:6];
    wire good_len = any_q && cnt_q == 3'h0;
    wire is_dcr_write = cmd == spi_diag_pkg::CMD_DIAG
        && shift_q[5:3] == spi_diag_pkg::DCR_SEL_CODE;
    always_comb begin
        shift_d = shift_q;
        cnt_d = cnt_q;
        any_d = any_q;
        first_d = first_q;
        out_d = out_q;
        err_d = err_q;
        mux_d = mux_q;
        if (cs_fall) begin
            shift_d = (is_dcr_write) ? dcr_word : diag_word;
            cnt_d = 3'h0;
            any_d = 1'b0;
            first_d = 1'b1;
        end else if (sclk_rise) begin
            first_d = 1'b0;
            out_d = shift_q[7];
        end else if (sclk_fall) begin
            shift_d = {shift_q[6:0], mosi};
            cnt_d = cnt_q + 3'h1;
            any_d = 1'b1;
        end else if (cs_rise) begin
            if (!good_len) begin
                err_d = 1'b1;
            end else begin
                err_d = 1'b0;
                if (is_dcr_write) begin
                    mux_d = shift_q[spi_diag_pkg::MUX_MSB:0];
                end
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            shift_q <= 8'h00;
            cnt_q <= 3'h0;
            any_q <= 1'b0;
            first_q <= 1'b0;
            out_q <= 1'b0;
            err_q <= 1'b0;
            mux_q <= spi_diag_pkg::MUX_RESET;
        end else begin
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            any_q <= any_d;
            first_q <= first_d;
            out_q <= out_d;
            err_q <= err_d;
            mux_q <= mux_d;
        end
    end
    // ****************************************************************
    // serial output
    // ****************************************************************
    assign LINK.miso = first_q ? (err_q | mosi) : out_q;
    assign LINK.miso_oe = ~cs_n;
    // ****************************************************************
    // current sense routing
    // ****************************************************************
    wire active_code = mux_q < spi_diag_pkg::MUX_OFF;
    wire ch_on = active_code && CHANNEL_ON[mux_q];
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            mux_prev_q <= spi_diag_pkg::MUX_RESET;
            settle_q <= 10'h000;
        end else begin
            mux_prev_q <= mux_q;
            if (mux_q != mux_prev_q || !ch_on) begin
                settle_q <= 10'h000;
            end else if (settle_q
                    != 10'(spi_diag_pkg::SENSE_SETTLE_CYC)) begin
                settle_q <= settle_q + 10'h001;
            end
        end
    end
    assign SENSE_ROUTE_SEL = mux_q;
    assign SENSE_ENABLE = ch_on;
    assign SENSE_CHANNEL = mux_q;
    assign SENSE_VALID = ch_on
        && settle_q == 10'(spi_diag_pkg::SENSE_SETTLE_CYC);
    assign FRAME_ERROR = err_q;
endmodule

// file: spi_diag_host.sv
`timescale 1ns/10ps
module spi_diag_host (
    input wire logic CLK,
    input wire logic RESETN,
    spi_diag_if.host LINK,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA
);
    logic [7:0] tx_q, rx_q, sh_q, rd_q;
    logic [2:0] chain_q;
    logic busy_q, cs_q, sclk_q, mosi_q, m1_q, m2_q;
    logic [5:0] bits_q;
    logic [5:0] tim_q;
    spi_diag_pkg::host_state_type st_q;
    wire start = WR && ADDR == spi_diag_pkg::ADDR_CTRL && !busy_q;
    wire [5:0] total = {chain_q, 3'h0};
    wire tdone = tim_q == 6'h00;
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            m1_q <= 1'b0;
            m2_q <= 1'b0;
        end else begin
            m1_q <= LINK.miso;
            m2_q <= m1_q;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st_q <= spi_diag_pkg::H_IDLE;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            sh_q <= 8'h00;
            chain_q <= 3'h1;
            busy_q <= 1'b0;
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            bits_q <= 6'h00;
            tim_q <= 6'h00;
        end else begin
            if (WR && ADDR == spi_diag_pkg::ADDR_TXDATA) tx_q <= WDATA;
            if (WR && ADDR == spi_diag_pkg::ADDR_CHAIN && WDATA[2:0] != 3'h0)
                chain_q <= WDATA[2:0];
            if (!tdone) tim_q <= tim_q - 6'h01;
            case (st_q)
                spi_diag_pkg::H_IDLE: begin
                    if (start) begin
                        busy_q <= 1'b1;
                        cs_q <= 1'b0;
                        sh_q <= tx_q;
                        mosi_q <= tx_q[7];
                        bits_q <= 6'h00;
                        tim_q <= 6'(spi_diag_pkg::CS_GUARD_CYC);
                        st_q <= spi_diag_pkg::H_LEAD;
                    end
                end
                spi_diag_pkg::H_LEAD: begin
                    if (tdone) begin
                        sclk_q <= 1'b1;
                        tim_q <= 6'(spi_diag_pkg::SCLK_HALF_CYC);
                        st_q <= spi_diag_pkg::H_HIGH;
                    end
                end
                spi_diag_pkg::H_LOW: begin
                    if (tdone) begin
                        sclk_q <= 1'b1;
                        // next bit moves on the rise, away from sampling
                        mosi_q <= sh_q[7];
                        tim_q <= 6'(spi_diag_pkg::SCLK_HALF_CYC);
                        st_q <= spi_diag_pkg::H_HIGH;
                    end
                end
                spi_diag_pkg::H_HIGH: begin
                    if (tdone) begin
                        sclk_q <= 1'b0;
                        // capture miso late in high phase
                        rx_q <= {rx_q[6:0], m2_q};
                        // rotate so each chained device gets the word
                        sh_q <= {sh_q[6:0], sh_q[7]};
                        bits_q <= bits_q + 6'h01;
                        if (bits_q + 6'h01 == total) begin
                            tim_q <= 6'(spi_diag_pkg::CS_GUARD_CYC);
                            st_q <= spi_diag_pkg::H_LAG;
                        end else begin
                            tim_q <= 6'(spi_diag_pkg::SCLK_HALF_CYC);
                            st_q <= spi_diag_pkg::H_LOW;
                        end
                    end
                end
                spi_diag_pkg::H_LAG: begin
                    if (tdone) begin
                        cs_q <= 1'b1;
                        busy_q <= 1'b0;
                        st_q <= spi_diag_pkg::H_IDLE;
                    end
                end
                default: st_q <= spi_diag_pkg::H_IDLE;
            endcase
        end
    end
    wire [7:0] rsel = (ADDR == spi_diag_pkg::ADDR_TXDATA) ? tx_q :
        (ADDR == spi_diag_pkg::ADDR_STATUS) ? {7'h00, busy_q} :
        (ADDR == spi_diag_pkg::ADDR_RXDATA) ? rx_q :
        (ADDR == spi_diag_pkg::ADDR_CHAIN) ? {5'h00, chain_q} : 8'h00;
    always_ff @(posedge CLK) begin
        if (!RESETN) rd_q <= 8'h00;
        else if (RD) rd_q <= rsel;
    end
    assign RDATA = rd_q;
    assign LINK.cs_n = cs_q;
    assign LINK.sclk = sclk_q;
    assign LINK.mosi = mosi_q;
endmodule

// file: spi_diag_slave_port_monitor.sv
`timescale 1ns/10ps
module spi_diag_slave_port_monitor (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // ****
    // rising serial edges since select
    // ****
    logic [4:0] edges_q;
    logic sclk_q;
    always_ff @(posedge CLK) begin
        sclk_q <= sclk;
        if (!RESETN || cs_n)
            edges_q <= 5'h00;
        else if (sclk && !sclk_q)
            edges_q <= edges_q + 5'h01;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // ****
    // checks
    // ****
    oe_off_idle_a: assert property (cs_n [*6] |-> !miso_oe)
        else $error("output driven while deselected");
    oe_on_select_a: assert property ($fell(cs_n) |-> ##[1:6] miso_oe)
        else $error("output not driven after select");
    cs_edge_low_a: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
        else $error("select moved with clock high");
    sclk_in_frame_a: assert property (sclk |-> !cs_n)
        else $error("clock high while deselected");
    lead_quiet_a: assert property ($fell(cs_n) |-> (!sclk) [*8])
        else $error("clock too early after select");
    sclk_high_a: assert property ($rose(sclk) |-> sclk [*8])
        else $error("clock high phase short");
    mosi_hold_a: assert property ($fell(sclk) |-> $stable(mosi) ##1 $stable(mosi))
        else $error("input moved at sampling edge");
    frame_whole_a: assert property ($rose(cs_n) |-> edges_q[2:0] == 3'h0)
        else $error("frame not whole bytes");
    cover property ($rose(cs_n) && edges_q == 5'h08);
    cover property ($rose(cs_n) && edges_q == 5'h10);
    cover property ($fell(miso_oe));
endmodule

// file: spi_diag_slave_port_tb.sv
`timescale 1ns/10ps
module spi_diag_slave_port_tb;
    logic clk = 0, resetn = 0, wr = 0, rd = 0, byp = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [5:0] ch_on = 6'h00, ch_fault = 6'h00;
    logic [2:0] sel1, sel2, chan1;
    logic en1, valid1, err1, err2;
    logic [31:0] seed = 32'h92047501;
    int failures = 0, cmp_count = 0;
    spi_diag_if link1 ();
    spi_diag_if link2 ();
    always #12.5 clk = ~clk;
    initial begin
        link2.cs_n = 1'b1;
        link2.sclk = 1'b0;
        link2.mosi = 1'b0;
    end
    spi_diag_host i_spi_diag_host (.CLK(clk), .RESETN(resetn), .LINK(link1),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
    spi_diag_device i_spi_diag_device (.CLK(clk), .RESETN(resetn),
        .LINK(link1), .CHANNEL_ON(ch_on), .CHANNEL_FAULT(ch_fault),
        .BYPASS_ABOVE(byp), .SENSE_ROUTE_SEL(sel1), .SENSE_ENABLE(en1),
        .SENSE_CHANNEL(chan1), .SENSE_VALID(valid1), .FRAME_ERROR(err1));
    spi_diag_device i_spi_diag_device2 (.CLK(clk), .RESETN(resetn),
        .LINK(link2), .CHANNEL_ON(ch_on), .CHANNEL_FAULT(ch_fault),
        .BYPASS_ABOVE(byp), .SENSE_ROUTE_SEL(sel2), .SENSE_ENABLE(),
        .SENSE_CHANNEL(), .SENSE_VALID(), .FRAME_ERROR(err2));
    spi_diag_slave_port_monitor i_spi_diag_slave_port_monitor (.CLK(clk),
        .RESETN(resetn), .cs_n(link1.cs_n), .sclk(link1.sclk),
        .mosi(link1.mosi), .miso(link1.miso), .miso_oe(link1.miso_oe));
    // ****
    // helpers
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [7:0] e,
        input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // frame through the host: data, chain length, start, poll, result
    task automatic frame(input logic [7:0] tx, input logic [7:0] n,
        output logic [7:0] rx);
        logic [7:0] st;
        int k;
        reg_wr(4'h0, tx);
        reg_wr(4'h4, n);
        reg_wr(4'h1, 8'h01);
        st = 8'h01;
        for (k = 0; k < 3000 && st[0] !== 1'b0; k++)
            reg_rd(4'h2, st);
        reg_rd(4'h3, rx);
    endtask
    // bench-driven master on the second link, any bit count up to 8
    task automatic bang(input logic [7:0] d, input int n, input logic f);
        int i;
        @(posedge clk);
        link2.cs_n <= 1'b0;
        link2.mosi <= d[7];
        repeat (40) @(posedge clk);
        #1;
        chk("first out", {7'h00, f}, {7'h00, link2.miso});
        chk("out enable", 8'h01, {7'h00, link2.miso_oe});
        for (i = 0; i < n; i++) begin
            link2.mosi <= d[7 - i];
            repeat (2) @(posedge clk);
            link2.sclk <= 1'b1;
            repeat (4) @(posedge clk);
            link2.sclk <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (40) @(posedge clk);
        link2.cs_n <= 1'b1;
        link2.mosi <= ~link2.mosi;
        repeat (40) @(posedge clk);
        #1;
        chk("out release", 8'h00, {7'h00, link2.miso_oe});
    endtask
    // ****
    // tests
    // ****
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        final_report;
    end
    initial begin
        logic [7:0] rx;
        logic [5:0] on;
        int c;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        #1 chk("reset select", 8'h07, {5'h00, sel1});
        for (c = 0; c < 8; c++) begin
            seed = lfsr(seed);
            on = seed[5:0];
            on[c % 6] = c[0];
            @(posedge clk);
            ch_on <= on;
            ch_fault <= seed[13:8];
            byp <= seed[16];
            frame({5'h1f, c[2:0]}, 8'h01, rx);
            chk("diag word", {2'b00, seed[13:8]}, rx);
            chk("frame ok", 8'h00, {7'h00, err1});
            chk("select", {5'h00, c[2:0]}, {5'h00, sel1});
            chk("channel", {5'h00, c[2:0]}, {5'h00, chan1});
            chk("enable", {7'h00, c < 6 && on[c % 6]}, {7'h00, en1});
            if (c < 7) begin
                frame(8'hc0, 8'h01, rx);
                chk("ctrl word", {4'h0, seed[16], c[2:0]}, rx);
                repeat (spi_diag_pkg::SENSE_SETTLE_CYC) @(posedge clk);
                #1 chk("valid", {7'h00, c < 6 && on[c % 6]}, {7'h00, valid1});
            end
            $display("code %0d done", c);
        end
        frame(8'hfd, 8'h02, rx);
        chk("chain pass", 8'hfd, rx);
        chk("chain select", 8'h05, {5'h00, sel1});
        $display("chain done");
        bang(8'h3d, 7, 1'b0);
        chk("error set", 8'h01, {7'h00, err2});
        chk("select kept", 8'h07, {5'h00, sel2});
        bang(8'hfd, 8, 1'b1);
        chk("error clear", 8'h00, {7'h00, err2});
        chk("select new", 8'h05, {5'h00, sel2});
        $display("length done");
        final_report;
    end
endmodule
